// >>> core/escfs_defines.vh
// Purpose: constants for the motor fault supervisor
// Assumes: 50 MHz clock, 12-bit measurement and setpoint codes
// Notes: thresholds are module parameters; these are their defaults
`ifndef ESCFS_DEFINES_VH
`define ESCFS_DEFINES_VH
`define ESCFS_CLK_MHZ 50
`define ESCFS_OV_START_LIMIT 12'h0C_80
`define ESCFS_TEMP_LIMIT 12'h05_5A
`define ESCFS_TEMP_SHUTDOWN 12'h07_3A
`define ESCFS_TEMP_HYST 12'h00_50
`define ESCFS_PHASE_I_LIMIT 12'h0A_00
`define ESCFS_BUS_OFF_VALUE 12'h00_10
`define ESCFS_BUS_START_VALUE 12'h00_20
`define ESCFS_PULSE_OFF_US 1040
`define ESCFS_PULSE_START_US 1100
`define ESCFS_PULSE_TIMEOUT_MS 200
`define ESCFS_BUS_TIMEOUT_MS 200
`define ESCFS_COMM_MIN_CYC 20'h0_0100
`define ESCFS_COMM_MAX_CYC 20'hF_0000
`define ESCFS_TONE_HALF_CYC 16'h30_D4
`define ESCFS_ST_INIT 2'h0
`define ESCFS_ST_READY 2'h1
`define ESCFS_ST_RUN 2'h2
`define ESCFS_ST_LOCK 2'h3
`define ESCFS_EV_OV 0
`define ESCFS_EV_OTLIM 1
`define ESCFS_EV_OTOFF 2
`define ESCFS_EV_OC 3
`define ESCFS_EV_STALL 4
`define ESCFS_EV_TIMEOUT 5
`define ESCFS_EV_START 6
`define ESCFS_EV_W 7
`endif

// >>> core/escfs_supervisor.v
// Purpose: fault supervisor for one sensorless brushless motor controller
// Assumes: measurements are sampled codes on this clock; setpoint arrives
//          as a pulse line or as bus words flagged by a valid strobe
// Notes: outputs are registered; events pulse and also stay latched
`timescale 1ns/10ps
`include "escfs_defines.vh"
module escfs_supervisor
#(
    parameter [11:0] OV_START_LIMIT = `ESCFS_OV_START_LIMIT,
    parameter [11:0] TEMP_LIMIT = `ESCFS_TEMP_LIMIT,
    parameter [11:0] TEMP_SHUTDOWN = `ESCFS_TEMP_SHUTDOWN,
    parameter [11:0] TEMP_HYST = `ESCFS_TEMP_HYST,
    parameter [11:0] PHASE_I_LIMIT = `ESCFS_PHASE_I_LIMIT,
    parameter [11:0] BUS_OFF_VALUE = `ESCFS_BUS_OFF_VALUE,
    parameter [11:0] BUS_START_VALUE = `ESCFS_BUS_START_VALUE,
    parameter PULSE_OFF_US = `ESCFS_PULSE_OFF_US,
    parameter PULSE_START_US = `ESCFS_PULSE_START_US,
    parameter PULSE_TIMEOUT_MS = `ESCFS_PULSE_TIMEOUT_MS,
    parameter BUS_TIMEOUT_MS = `ESCFS_BUS_TIMEOUT_MS,
    parameter [23:0] PULSE_TIMEOUT_CYC =
        PULSE_TIMEOUT_MS * 1000 * `ESCFS_CLK_MHZ,
    parameter [23:0] BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * 1000 * `ESCFS_CLK_MHZ,
    parameter [19:0] COMM_MIN_CYC = `ESCFS_COMM_MIN_CYC,
    parameter [19:0] COMM_MAX_CYC = `ESCFS_COMM_MAX_CYC,
    parameter [15:0] TONE_HALF_CYC = `ESCFS_TONE_HALF_CYC
)
(
    // clock and reset
    input wire clock,
    input wire resetn,
    // configuration
    input wire mode_bus,
    // setpoint inputs
    input wire pulse_pin,
    input wire [11:0] bus_setpoint,
    input wire bus_setpoint_valid,
    input wire [11:0] pulse_full_scale_us,
    // measurements
    input wire [11:0] battery_voltage,
    input wire [11:0] stage_temp,
    input wire [11:0] phase_current,
    input wire commutation_tick,
    // motor drive
    output reg [11:0] power_cmd_q,
    output reg drive_enable_q,
    output reg tone_q,
    output reg [1:0] state_q,
    // telemetry
    output reg [6:0] event_pulse_q,
    output reg [6:0] event_latched_q,
    output reg [11:0] telem_voltage_q,
    output reg [11:0] telem_temp_q
);
    localparam [21:0] PULSE_OFF_CYC = PULSE_OFF_US * `ESCFS_CLK_MHZ;
    localparam [21:0] PULSE_START_CYC = PULSE_START_US * `ESCFS_CLK_MHZ;
    localparam [21:0] US_CYC = `ESCFS_CLK_MHZ;

    wire pulse_s;
    escfs_sync u_sync
    (
        .clock(clock),
        .resetn(resetn),
        .din(pulse_pin),
        .dout_q(pulse_s)
    );

    // pulse width measurement
    reg pulse_d1_q;
    reg [21:0] hi_cnt_q;
    reg [21:0] hi_width_q;
    reg pulse_done_q;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pulse_d1_q <= 1'b0;
            hi_cnt_q <= 22'h00_0000;
            hi_width_q <= 22'h00_0000;
            pulse_done_q <= 1'b0;
        end
        else
        begin
            pulse_d1_q <= pulse_s;
            pulse_done_q <= 1'b0;
            if (pulse_s && hi_cnt_q != 22'h3F_FFFF)
                hi_cnt_q <= hi_cnt_q + 22'h00_0001;
            if (pulse_d1_q && !pulse_s)
            begin
                hi_width_q <= hi_cnt_q;
                hi_cnt_q <= 22'h00_0000;
                pulse_done_q <= 1'b1;
            end
        end
    end

    // setpoint as 12-bit code; pulse width minus off time, scaled by us
    wire [21:0] pulse_above =
        (hi_width_q > PULSE_OFF_CYC) ? hi_width_q - PULSE_OFF_CYC : 22'h0;
    wire [21:0] pulse_us = pulse_above / US_CYC;
    wire [21:0] pulse_code = (pulse_us * 22'h00_0FFF) /
        {10'h000, (pulse_full_scale_us == 12'h000) ? 12'h001 :
        pulse_full_scale_us};
    wire [11:0] pulse_sp =
        (pulse_code > 22'h00_0FFF) ? 12'hFFF : pulse_code[11:0];
    wire new_sp = mode_bus ? bus_setpoint_valid : pulse_done_q;
    wire [11:0] sp_now = mode_bus ? bus_setpoint : pulse_sp;
    wire sp_off = mode_bus ? (bus_setpoint < BUS_OFF_VALUE) :
        (hi_width_q < PULSE_OFF_CYC);
    wire sp_start = mode_bus ? (bus_setpoint > BUS_START_VALUE) :
        (hi_width_q > PULSE_START_CYC);

    // setpoint timeout per active mode
    reg [23:0] to_cnt_q;
    reg timed_out_q;
    wire [23:0] to_lim = mode_bus ? BUS_TIMEOUT_CYC : PULSE_TIMEOUT_CYC;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            to_cnt_q <= 24'h00_0000;
            timed_out_q <= 1'b0;
        end
        else if (new_sp)
        begin
            to_cnt_q <= 24'h00_0000;
            timed_out_q <= 1'b0;
        end
        else if (to_cnt_q >= to_lim)
            timed_out_q <= 1'b1;
        else
            to_cnt_q <= to_cnt_q + 24'h00_0001;
    end

    // commutation interval check
    reg [19:0] comm_cnt_q;
    reg stall_evt;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            comm_cnt_q <= 20'h0_0000;
        else if (state_q != `ESCFS_ST_RUN || commutation_tick)
            comm_cnt_q <= 20'h0_0000;
        else if (comm_cnt_q != 20'hF_FFFF)
            comm_cnt_q <= comm_cnt_q + 20'h0_0001;
    end
    always @*
    begin
        stall_evt = 1'b0;
        if (state_q == `ESCFS_ST_RUN)
        begin
            if (commutation_tick && comm_cnt_q < COMM_MIN_CYC)
                stall_evt = 1'b1;
            if (comm_cnt_q >= COMM_MAX_CYC)
                stall_evt = 1'b1;
        end
    end

    // temperature limitation with hysteresis
    reg ot_lim_q;
    wire [12:0] rel_point = {1'b0, TEMP_LIMIT} - {1'b0, TEMP_HYST};
    wire below_rel = rel_point[12] ? 1'b0 : (stage_temp < rel_point[11:0]);
    wire ot_hot = stage_temp > TEMP_SHUTDOWN;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            ot_lim_q <= 1'b0;
        else if (stage_temp > TEMP_LIMIT)
            ot_lim_q <= 1'b1;
        else if (below_rel)
            ot_lim_q <= 1'b0;
    end

    // supervisor state machine
    reg [1:0] state_d;
    reg lock_ot_q;
    reg lock_ot_d;
    reg started_q;
    reg refused_start;
    reg ov_block;
    always @*
    begin
        state_d = state_q;
        lock_ot_d = lock_ot_q;
        refused_start = 1'b0;
        ov_block = 1'b0;
        case (state_q)
            `ESCFS_ST_INIT:
            begin
                if (new_sp && sp_start)
                    refused_start = 1'b1;
                else if (new_sp && sp_off)
                    state_d = `ESCFS_ST_READY;
            end
            `ESCFS_ST_READY:
            begin
                ov_block = !started_q &&
                    (battery_voltage > OV_START_LIMIT);
                if (new_sp && !sp_off && !timed_out_q)
                begin
                    if (ov_block)
                        refused_start = 1'b1;
                    else
                        state_d = `ESCFS_ST_RUN;
                end
            end
            `ESCFS_ST_RUN:
            begin
                // voltage is not looked at here
                if (ot_hot)
                begin
                    state_d = `ESCFS_ST_LOCK;
                    lock_ot_d = 1'b1;
                end
                else if (stall_evt)
                begin
                    state_d = `ESCFS_ST_LOCK;
                    lock_ot_d = 1'b0;
                end
                else if (timed_out_q || (new_sp && sp_off))
                    state_d = `ESCFS_ST_READY;
            end
            `ESCFS_ST_LOCK:
            begin
                if (new_sp && sp_off && !(lock_ot_q && ot_hot))
                begin
                    state_d = `ESCFS_ST_READY;
                    lock_ot_d = 1'b0;
                end
            end
            default:
                state_d = `ESCFS_ST_INIT;
        endcase
    end

    // events, overcurrent never changes state
    wire oc_now = phase_current > PHASE_I_LIMIT;
    wire [6:0] ev_now;
    assign ev_now[`ESCFS_EV_OV] = refused_start && state_q == `ESCFS_ST_READY;
    assign ev_now[`ESCFS_EV_OTLIM] = ot_lim_q && state_q == `ESCFS_ST_RUN;
    assign ev_now[`ESCFS_EV_OTOFF] = ot_hot && state_q == `ESCFS_ST_RUN;
    assign ev_now[`ESCFS_EV_OC] = oc_now && state_q == `ESCFS_ST_RUN;
    assign ev_now[`ESCFS_EV_STALL] = stall_evt && !ot_hot;
    assign ev_now[`ESCFS_EV_TIMEOUT] = timed_out_q &&
        state_q == `ESCFS_ST_RUN;
    assign ev_now[`ESCFS_EV_START] = refused_start &&
        state_q == `ESCFS_ST_INIT;

    // power shaping: halve for temperature, step down for overcurrent
    reg [11:0] oc_scale_q;
    reg [11:0] sp_hold_q;
    wire [11:0] sp_req = new_sp ? sp_now : sp_hold_q;
    wire [11:0] sp_half = ot_lim_q ? {1'b0, sp_req[11:1]} : sp_req;
    wire [23:0] sp_scaled = sp_half * oc_scale_q;
    reg [15:0] tone_cnt_q;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= `ESCFS_ST_INIT;
            lock_ot_q <= 1'b0;
            started_q <= 1'b0;
            oc_scale_q <= 12'hFFF;
            sp_hold_q <= 12'h000;
            power_cmd_q <= 12'h000;
            drive_enable_q <= 1'b0;
            tone_q <= 1'b0;
            tone_cnt_q <= 16'h0000;
            event_pulse_q <= 7'h00;
            event_latched_q <= 7'h00;
            telem_voltage_q <= 12'h000;
            telem_temp_q <= 12'h000;
        end
        else
        begin
            state_q <= state_d;
            lock_ot_q <= lock_ot_d;
            if (state_q == `ESCFS_ST_RUN)
                started_q <= 1'b1;
            if (oc_now && oc_scale_q != 12'h000)
                oc_scale_q <= oc_scale_q - 12'h001;
            else if (!oc_now && oc_scale_q != 12'hFFF)
                oc_scale_q <= oc_scale_q + 12'h001;
            if (new_sp)
                sp_hold_q <= sp_now;
            if (state_d == `ESCFS_ST_RUN)
            begin
                drive_enable_q <= 1'b1;
                power_cmd_q <= sp_scaled[23:12];
            end
            else
            begin
                drive_enable_q <= 1'b0;
                power_cmd_q <= 12'h000;
            end
            if (state_q == `ESCFS_ST_LOCK && lock_ot_q)
            begin
                if (tone_cnt_q >= TONE_HALF_CYC)
                begin
                    tone_cnt_q <= 16'h0000;
                    tone_q <= !tone_q;
                end
                else
                    tone_cnt_q <= tone_cnt_q + 16'h0001;
            end
            else
            begin
                tone_cnt_q <= 16'h0000;
                tone_q <= 1'b0;
            end
            event_pulse_q <= ev_now;
            event_latched_q <= event_latched_q | ev_now;
            telem_voltage_q <= battery_voltage;
            telem_temp_q <= stage_temp;
        end
    end
endmodule // escfs_supervisor

// >>> core/escfs_sync.v
// Purpose: three-stage synchroniser for a pin level
// Assumes: one clock domain
// Notes: change accepted once stages two and three agree
`timescale 1ns/10ps
`include "escfs_defines.vh"
module escfs_sync
(
    // clock and reset
    input wire clock,
    input wire resetn,
    // level in and out
    input wire din,
    output reg dout_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout_q <= 1'b0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                dout_q <= s3_q;
        end
    end
endmodule // escfs_sync

// >>> verification/esc_fault_supervisor_test.sv
// Purpose: self-checking bench for the motor fault supervisor
// Assumes: setpoints come from the flight controller model
// Notes: bus timeout shortened to 200 cycles, pulse timings scaled down
`timescale 1ns/10ps
module esc_fault_supervisor_test;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic mode_bus = 1'b1;
    logic tick = 1'b0;
    logic [11:0] volt = 12'h400;
    logic [11:0] temp = 12'h100;
    logic [11:0] cur = 12'h100;
    logic [11:0] fs = 12'h3E8;
    logic t0;
    wire [11:0] sp, pc, tv, tt;
    wire spv, pin, de, tn;
    wire [1:0] st;
    wire [6:0] ep, el;
    int fails = 0;
    int total_checks = 0;
    int i;
    always #10 clock = ~clock;
    escfs_flight_ctl fc (.clock(clock), .bus_setpoint(sp),
        .bus_setpoint_valid(spv), .pulse_pin(pin));
    escfs_supervisor #(.PULSE_TIMEOUT_CYC(24'h00_2000),
        .BUS_TIMEOUT_CYC(24'h00_00C8), .PULSE_OFF_US(20),
        .PULSE_START_US(30)) dut (
        .clock(clock), .resetn(resetn), .mode_bus(mode_bus),
        .pulse_pin(pin), .bus_setpoint(sp), .bus_setpoint_valid(spv),
        .pulse_full_scale_us(fs), .battery_voltage(volt),
        .stage_temp(temp), .phase_current(cur), .commutation_tick(tick),
        .power_cmd_q(pc), .drive_enable_q(de), .tone_q(tn), .state_q(st),
        .event_pulse_q(ep), .event_latched_q(el), .telem_voltage_q(tv),
        .telem_temp_q(tt));
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task chk(input logic c);
        total_checks++;
        if (c !== 1'b1)
        begin
            fails++;
            $display("FAIL at %0t: check %0d", $time, total_checks);
        end
    endtask
    // wait a bounded time for one event pulse
    task ev(input int b, input int n);
        for (i = 0; i < n && ep[b] !== 1'b1; i++) @(negedge clock);
        chk(ep[b]);
    endtask
    task conclude;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #1_000_000;
        fails++;
        conclude;
    end
    initial
    begin
        cyc(20);
        resetn = 1'b1;
        cyc(1);
        chk(st === 2'h0 && de === 1'b0 && el === 7'h00);
        fc.send(12'h800);
        ev(6, 8);
        chk(st === 2'h0);
        mode_bus = 1'b0;
        fc.pulse(10);
        cyc(8);
        chk(st === 2'h1);
        $display("test power_up done");
        mode_bus = 1'b1;
        fc.send(12'h000);
        volt = 12'hD00;
        fc.send(12'h800);
        ev(0, 8);
        chk(st === 2'h1);
        volt = 12'h400;
        fc.send(12'h800);
        cyc(2);
        chk(st === 2'h2 && de === 1'b1 && pc >= 12'h7F0);
        volt = 12'hD00;
        cyc(4);
        chk(st === 2'h2 && tv === 12'hD00 && tt === 12'h100);
        $display("test voltage done");
        temp = 12'h5A0;
        ev(1, 8);
        cyc(4);
        chk(st === 2'h2 && pc >= 12'h3F0 && pc <= 12'h400);
        temp = 12'h520;
        cyc(4);
        chk(pc <= 12'h400);
        temp = 12'h4F0;
        cyc(4);
        chk(pc >= 12'h7F0);
        temp = 12'h780;
        ev(2, 8);
        chk(st === 2'h3 && de === 1'b0);
        t0 = tn;
        for (i = 0; i < 13000 && tn === t0; i++) @(negedge clock);
        chk(tn !== t0);
        fc.send(12'h000);
        cyc(3);
        chk(st === 2'h3);
        temp = 12'h100;
        fc.send(12'h800);
        cyc(3);
        chk(st === 2'h3);
        fc.send(12'h000);
        cyc(3);
        chk(st === 2'h1);
        $display("test temperature done");
        fc.send(12'h800);
        cyc(2);
        chk(st === 2'h2);
        cur = 12'hB00;
        ev(3, 8);
        cyc(100);
        chk(st === 2'h2 && pc < 12'h7E0);
        cur = 12'h100;
        fc.send(12'h800);
        cyc(150);
        chk(pc >= 12'h7F0);
        $display("test overcurrent done");
        fc.send(12'h800);
        cyc(120);
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        chk(st === 2'h2 && ep[4] === 1'b0);
        cyc(1);
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        ev(4, 20);
        chk(st === 2'h3 && el[4] === 1'b1);
        fc.send(12'h800);
        cyc(3);
        chk(st === 2'h3);
        fc.send(12'h000);
        cyc(3);
        chk(st === 2'h1);
        $display("test stall done");
        fc.send(12'h800);
        cyc(2);
        chk(st === 2'h2);
        ev(5, 260);
        cyc(2);
        chk(st === 2'h1 && de === 1'b0);
        $display("test timeout done");
        fc.send(12'h000);
        mode_bus = 1'b0;
        fs = 12'h064;
        fc.pulse(60);
        cyc(8);
        chk(st === 2'h2 && pc >= 12'h660 && pc <= 12'h668);
        fs = 12'h032;
        fc.pulse(60);
        cyc(8);
        chk(st === 2'h2 && pc >= 12'hCC0 && pc <= 12'hCD0);
        fc.pulse(10);
        cyc(8);
        chk(st === 2'h1 && de === 1'b0 && pc === 12'h000);
        $display("test pulse done");
        conclude;
    end
endmodule // esc_fault_supervisor_test

// >>> verification/escfs_flight_ctl.sv
// Purpose: flight controller model sending motor setpoints
// Assumes: drives on the falling clock edge
// Notes: released bus data shows the inverse of the last word
`timescale 1ns/10ps
module escfs_flight_ctl
(
    // clock
    input wire clock,
    // setpoint outputs
    output logic [11:0] bus_setpoint,
    output logic bus_setpoint_valid,
    output logic pulse_pin
);
    initial
    begin
        bus_setpoint = 12'h000;
        bus_setpoint_valid = 1'b0;
        pulse_pin = 1'b0;
    end
    // one bus word, valid for one cycle
    task send(input logic [11:0] word);
        @(negedge clock);
        bus_setpoint = word;
        bus_setpoint_valid = 1'b1;
        @(negedge clock);
        bus_setpoint_valid = 1'b0;
        bus_setpoint = ~word;
    endtask
    // one high pulse, width in microseconds
    task pulse(input int us);
        @(negedge clock);
        pulse_pin = 1'b1;
        repeat (us * 50) @(negedge clock);
        pulse_pin = 1'b0;
    endtask
endmodule // escfs_flight_ctl

// >>> verification/escfs_props.sv
// Purpose: port checks on the motor fault supervisor
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every supervisor instance
`timescale 1ns/10ps
module escfs_props
#(
    parameter [11:0] OV_START_LIMIT = 12'hC80,
    parameter [11:0] BUS_START_VALUE = 12'h020,
    parameter [11:0] PHASE_I_LIMIT = 12'hA00
)
(
    // clock and reset
    input wire clock,
    input wire resetn,
    // watched inputs
    input wire mode_bus,
    input wire [11:0] bus_setpoint,
    input wire bus_setpoint_valid,
    input wire [11:0] battery_voltage,
    input wire [11:0] stage_temp,
    input wire [11:0] phase_current,
    // watched outputs
    input wire [11:0] power_cmd_q,
    input wire drive_enable_q,
    input wire tone_q,
    input wire [1:0] state_q,
    input wire [6:0] event_pulse_q,
    input wire [6:0] event_latched_q
);
    // set once the motor has run since reset
    reg ran_q;
    always @(posedge clock or negedge resetn)
        if (!resetn)
            ran_q <= 1'b0;
        else if (state_q == 2'h2)
            ran_q <= 1'b1;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence start_req;
        mode_bus && bus_setpoint_valid && bus_setpoint > BUS_START_VALUE;
    endsequence
    sequence over_i;
        (phase_current > PHASE_I_LIMIT && !bus_setpoint_valid
            && $stable(stage_temp))[*3];
    endsequence
    init_refuse_a: assert property (
        state_q == 2'h0 ##0 start_req |=> state_q == 2'h0)
        else $error("start taken in init");
    ov_refuse_a: assert property (
        state_q == 2'h1 && !ran_q && battery_voltage > OV_START_LIMIT
        ##0 start_req |=> state_q == 2'h1)
        else $error("start taken with high voltage");
    idle_drive_a: assert property (
        state_q != 2'h2 |-> !drive_enable_q && power_cmd_q == 12'h000)
        else $error("drive active outside run");
    oc_limit_a: assert property (
        over_i |=> power_cmd_q <= $past(power_cmd_q))
        else $error("power rose under overcurrent");
    stall_lock_a: assert property (
        event_pulse_q[4] |-> ##[0:2] state_q == 2'h3)
        else $error("stall without lock");
    lock_exit_a: assert property (
        $past(state_q) == 2'h3 && state_q != 2'h3 |-> state_q == 2'h1)
        else $error("lock left to wrong state");
    tone_lock_a: assert property (
        $changed(tone_q) |-> $past(state_q) == 2'h3
            || $past(state_q, 2) == 2'h3)
        else $error("tone outside lock");
    event_latch_a: assert property (
        event_pulse_q != 7'h00 |=> (event_latched_q & $past(event_pulse_q))
            == $past(event_pulse_q))
        else $error("event not latched");
endmodule // escfs_props
bind escfs_supervisor escfs_props #(.OV_START_LIMIT(OV_START_LIMIT),
    .BUS_START_VALUE(BUS_START_VALUE), .PHASE_I_LIMIT(PHASE_I_LIMIT)) props (
    .clock(clock), .resetn(resetn), .mode_bus(mode_bus),
    .bus_setpoint(bus_setpoint), .bus_setpoint_valid(bus_setpoint_valid),
    .battery_voltage(battery_voltage), .stage_temp(stage_temp),
    .phase_current(phase_current), .power_cmd_q(power_cmd_q),
    .drive_enable_q(drive_enable_q), .tone_q(tone_q), .state_q(state_q),
    .event_pulse_q(event_pulse_q), .event_latched_q(event_latched_q));
